// File: hdl/ipm_pkg.sv
// Constants for the interrupt priority resolver and power mode block.
// Assumes an 8051-class core reaching registers as SFRs on sys_clk.
package ipm_pkg;
    // ------------------------------------------------------------------
    // Register addresses and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] PRIO_LOW_BITS_ADDR      = 8'ha9;
    localparam logic [7:0] PRIO_HIGH_BITS_ADDR     = 8'hb9;
    localparam logic [7:0] POWER_MODE_RESET        = 8'h40;
    localparam logic [5:0] PRIO_RESET              = 6'h00;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IDLE_BIT    = 0;
    localparam int STOP_BIT    = 1;
    localparam int DOUBLER_BIT = 7;
    localparam int BIT6_POS    = 6;
    // ------------------------------------------------------------------
    // Sources, in polling order
    // ------------------------------------------------------------------
    localparam int NSRC = 10;
    localparam int NGRP = 6;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_PWM  = 1;
    localparam int SRC_T0   = 2;
    localparam int SRC_SPI  = 3;
    localparam int SRC_EXT1 = 4;
    localparam int SRC_T1   = 5;
    localparam int SRC_SER0 = 6;
    localparam int SRC_LVD  = 7;
    localparam int SRC_T2   = 8;
    localparam int SRC_I2C  = 9;
    // Group of each source, indexed by polling position.
    localparam int SRC_GROUP [NSRC] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5};
    // Entry addresses, indexed by polling position.
    localparam logic [15:0] SRC_VECTOR [NSRC] = '{
        16'h0003, 16'h0043, 16'h000b, 16'h004b, 16'h0013,
        16'h001b, 16'h0023, 16'h0063, 16'h002b, 16'h006b};
    // ------------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IPM_RUN  = 2'b00,
        IPM_IDLE = 2'b01,
        IPM_STOP = 2'b10
    } ipm_pwr_t;
endpackage : ipm_pkg

// File: hdl/ipm_ctrl.sv
// Interrupt priority resolver with idle and stop power modes.
// Assumes request lines and SFR strobes are synchronous to sys_clk; the
// wake-capable pins are synchronised here.
`timescale 1ns/10ps
module ipm_ctrl
    import ipm_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic [7:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic [7:0]        sfr_wdata,
    output logic      [7:0]        sfr_rdata,
    input  wire logic [NSRC-1:0]   irq_req,
    input  wire logic              ext0_pin_req,
    input  wire logic              ext1_pin_req,
    input  wire logic              lvd_pin_req,
    input  wire logic              irq_ack,
    input  wire logic              irq_ret,
    output logic                   irq_valid,
    output logic      [15:0]       irq_vector,
    output logic                   cpu_halt,
    output logic                   clk_gate_off,
    output logic                   baud_doubler
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [5:0]  prio_low_ff, nxt_prio_low;
    logic [5:0]  prio_high_ff, nxt_prio_high;
    logic        doubler_ff, nxt_doubler;
    logic        bit6_ff, nxt_bit6;
    ipm_pwr_t    pwr_ff, nxt_pwr;
    logic [3:0]  active_ff, nxt_active;  // One bit per level in service.
    logic [2:0]  wake_s1_ff, wake_s2_ff;
    logic        valid_ff, nxt_valid;
    logic [15:0] vector_ff, nxt_vector;
    logic [1:0]  lvl_ff, nxt_lvl;        // Level of the standing offer.
    logic [1:0]  src_lvl [NSRC];
    logic        best_found;
    logic [1:0]  best_lvl;
    logic [15:0] best_vec;
    logic [1:0]  cur_lvl;
    logic        cur_any;
    logic        pin_wake;
    logic        stop_req;

    // Level of each source from its group's bit pair.
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_lvl
            assign src_lvl[gi] = {prio_high_ff[SRC_GROUP[gi]],
                                  prio_low_ff[SRC_GROUP[gi]]};
        end
    endgenerate

    // ------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------
    // Scan downward so the earliest polled source wins ties at a level.
    always_comb begin
        best_found = 1'b0;
        best_lvl   = 2'b00;
        best_vec   = 16'h0000;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (irq_req[i] && (!best_found || src_lvl[i] >= best_lvl)) begin
                best_found = 1'b1;
                best_lvl   = src_lvl[i];
                best_vec   = SRC_VECTOR[i];
            end
        end
        cur_any = |active_ff;
        cur_lvl = active_ff[3] ? 2'd3 : active_ff[2] ? 2'd2 :
                  active_ff[1] ? 2'd1 : 2'd0;
    end

    // Wake pins pass two flops; only the second stage is read.
    // A pin pulse shorter than a clock period may be missed, so wake pins
    // are expected to stay high until the core runs again.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wake_s1_ff <= 3'h0;
            wake_s2_ff <= 3'h0;
        end else begin
            wake_s1_ff <= {lvd_pin_req, ext1_pin_req, ext0_pin_req};
            wake_s2_ff <= wake_s1_ff;
        end
    end
    assign pin_wake = |wake_s2_ff;

    // A write that enters stop, seen in the cycle of the write itself.
    // The offer is dropped on that cycle so that it never stands in stop.
    assign stop_req = sfr_wr && (sfr_addr == POWER_MODE_CONTROL_ADDR) &&
                      sfr_wdata[STOP_BIT];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_prio_low  = prio_low_ff;
        nxt_prio_high = prio_high_ff;
        nxt_doubler   = doubler_ff;
        nxt_bit6      = bit6_ff;
        nxt_pwr       = pwr_ff;
        nxt_active    = active_ff;
        nxt_valid     = valid_ff;
        nxt_vector    = vector_ff;
        nxt_lvl       = lvl_ff;
        if (sfr_wr) begin
            case (sfr_addr)
                PRIO_LOW_BITS_ADDR:  nxt_prio_low  = sfr_wdata[5:0];
                PRIO_HIGH_BITS_ADDR: nxt_prio_high = sfr_wdata[5:0];
                POWER_MODE_CONTROL_ADDR: begin
                    nxt_doubler = sfr_wdata[DOUBLER_BIT];
                    nxt_bit6    = sfr_wdata[BIT6_POS];
                    if (sfr_wdata[STOP_BIT]) begin
                        nxt_pwr = IPM_STOP;
                    end else if (sfr_wdata[IDLE_BIT]) begin
                        nxt_pwr = IPM_IDLE;
                    end
                end
                default: ;
            endcase
        end
        // Return from service drops the highest active level.
        if (irq_ret && cur_any) begin
            nxt_active[cur_lvl] = 1'b0;
        end
        // Offer a request only while the core clock runs. The ack marks the
        // level that was offered, not the current winner, since requests may
        // change between the offer and the ack.
        if (irq_ack && valid_ff) begin
            nxt_active[lvl_ff] = 1'b1;
            nxt_valid = 1'b0;
        end else if (stop_req || pwr_ff == IPM_STOP) begin
            nxt_valid = 1'b0;
        end else begin
            nxt_valid  = best_found && (!cur_any || best_lvl > cur_lvl);
            nxt_vector = best_vec;
            nxt_lvl    = best_lvl;
        end
        case (pwr_ff)
            IPM_IDLE: begin
                if (valid_ff) begin
                    nxt_pwr = IPM_RUN;
                end
            end
            IPM_STOP: begin
                if (pin_wake) begin
                    nxt_pwr = IPM_RUN;
                end
            end
            IPM_RUN: ;
            default: nxt_pwr = IPM_RUN;
        endcase
    end

    // Reset here stands for every reset source, which also ends both modes.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prio_low_ff  <= PRIO_RESET;
            prio_high_ff <= PRIO_RESET;
            doubler_ff   <= POWER_MODE_RESET[DOUBLER_BIT];
            bit6_ff      <= POWER_MODE_RESET[BIT6_POS];
            pwr_ff       <= IPM_RUN;
            active_ff    <= 4'h0;
            valid_ff     <= 1'b0;
            vector_ff    <= 16'h0000;
            lvl_ff       <= 2'b00;
        end else begin
            prio_low_ff  <= nxt_prio_low;
            prio_high_ff <= nxt_prio_high;
            doubler_ff   <= nxt_doubler;
            bit6_ff      <= nxt_bit6;
            pwr_ff       <= nxt_pwr;
            active_ff    <= nxt_active;
            valid_ff     <= nxt_valid;
            vector_ff    <= nxt_vector;
            lvl_ff       <= nxt_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Read-back and outputs
    // ------------------------------------------------------------------
    // Mode bits are triggers, not storage, so they read as zero.
    always_comb begin
        case (sfr_addr)
            PRIO_LOW_BITS_ADDR:  sfr_rdata = {2'b00, prio_low_ff};
            PRIO_HIGH_BITS_ADDR: sfr_rdata = {2'b00, prio_high_ff};
            POWER_MODE_CONTROL_ADDR:
                sfr_rdata = {doubler_ff, bit6_ff, 6'h00};
            default: sfr_rdata = 8'h00;
        endcase
    end

    // Both halt outputs decode the power state register alone, so they
    // change only on clock edges and cannot glitch into the clock gate.
    assign irq_valid    = valid_ff;
    assign irq_vector   = vector_ff;
    assign cpu_halt     = (pwr_ff != IPM_RUN);
    assign clk_gate_off = (pwr_ff == IPM_STOP);
    assign baud_doubler = doubler_ff;

endmodule // ipm_ctrl

// File: bench/ipm_core_model.sv
// Core-side partner: takes offered interrupts and keeps the vector taken.
// Assumes the bench stalls it through ack_en and pulses irq_ret itself.
`timescale 1ns/10ps
module ipm_core_model (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        irq_valid,
    input  wire logic [15:0] irq_vector,
    input  wire logic        ack_en,
    output logic             irq_ack,
    output logic [15:0]      took_vec
);
    // Ack a cycle after the offer, never twice running, so ack meets valid.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_ack  <= 1'b0;
            took_vec <= 16'h0000;
        end else begin
            irq_ack <= irq_valid && ack_en && !irq_ack;
            if (irq_ack && irq_valid)
                took_vec <= irq_vector;
        end
    end
endmodule // ipm_core_model

// File: bench/ipm_ctrl_chk.sv
// Port checker for the interrupt resolver and power modes.
// Assumes it is bound onto ipm_ctrl and sees only its ports.
`timescale 1ns/10ps
module ipm_ctrl_chk
    import ipm_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [9:0] irq_req,
    input wire logic       ext0_pin_req,
    input wire logic       ext1_pin_req,
    input wire logic       lvd_pin_req,
    input wire logic       irq_ack,
    input wire logic       irq_valid,
    input wire logic       cpu_halt,
    input wire logic       clk_gate_off
);
    // ------------------------------------------------------------------
    // Power mode and offer relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic pw;
    logic pins;
    // A write to the power register, and any wake pin being high.
    assign pw = sfr_wr && sfr_addr == POWER_MODE_CONTROL_ADDR;
    assign pins = ext0_pin_req || ext1_pin_req || lvd_pin_req;
    stop_no_offer_a: assert property (clk_gate_off |-> !irq_valid)
        else $error("offer made while stopped");
    mode_bits_zero_a: assert property (
        sfr_addr == POWER_MODE_CONTROL_ADDR |-> sfr_rdata[1:0] == 2'b00)
        else $error("mode bits read nonzero");
    idle_entry_a: assert property (pw && sfr_wdata[IDLE_BIT] &&
        !sfr_wdata[STOP_BIT] && !irq_valid && irq_req == 10'h000
        |=> cpu_halt && !clk_gate_off) else $error("idle not entered");
    stop_entry_a: assert property (pw && sfr_wdata[STOP_BIT]
        |=> clk_gate_off && cpu_halt) else $error("stop not entered");
    idle_wake_a: assert property (cpu_halt && !clk_gate_off &&
        irq_valid && !sfr_wr |=> !cpu_halt) else $error("idle not left");
    stop_hold_a: assert property ((clk_gate_off && !pins)[*3]
        |=> clk_gate_off) else $error("stop left without wake pin");
    ack_drop_a: assert property (irq_valid && irq_ack
        |=> !irq_valid) else $error("offer kept after ack");
    reset_wake_a: assert property ($rose(resetn)
        |-> !cpu_halt && !clk_gate_off) else $error("halt after reset");
endmodule // ipm_ctrl_chk
bind ipm_ctrl ipm_ctrl_chk u_chk (.sys_clk(sys_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq_req(irq_req), .ext0_pin_req(ext0_pin_req),
    .ext1_pin_req(ext1_pin_req), .lvd_pin_req(lvd_pin_req),
    .irq_ack(irq_ack), .irq_valid(irq_valid), .cpu_halt(cpu_halt),
    .clk_gate_off(clk_gate_off));

// File: bench/tb_ipm_ctrl.sv
// Self-checking bench for the interrupt resolver and power modes.
// Assumes the package, the design, the core model and the checker.
`timescale 1ns/10ps
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_ipm_ctrl import ipm_pkg::*;;
    logic sys_clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, irq_ret = 1'b0;
    logic ack_en = 1'b0, irq_ack, irq_valid, cpu_halt, clk_gate_off;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [9:0] irq_req = 10'h000;
    logic [2:0] pins = 3'h0;
    logic [15:0] irq_vector, took_vec;
    logic baud_doubler;
    logic [5:0] lo, hi;
    int num_errors = 0, checked = 0, n;
    // Free-running clock; the reset pulse is made by the main sequence.
    always #4 sys_clk = ~sys_clk;
    ipm_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .irq_req(irq_req), .ext0_pin_req(pins[0]), .ext1_pin_req(pins[1]),
        .lvd_pin_req(pins[2]), .irq_ack(irq_ack), .irq_ret(irq_ret),
        .irq_valid(irq_valid), .irq_vector(irq_vector),
        .cpu_halt(cpu_halt), .clk_gate_off(clk_gate_off),
        .baud_doubler(baud_doubler));
    ipm_core_model core (.sys_clk(sys_clk), .resetn(resetn),
        .irq_valid(irq_valid), .irq_vector(irq_vector), .ack_en(ack_en),
        .irq_ack(irq_ack), .took_vec(took_vec));
    // Winner: highest level first, ties go to the earlier polling place.
    function automatic logic [15:0] exp_vec(logic [9:0] rq);
        int b = 0, bl = -1, lv;
        for (int i = 0; i < NSRC; i++) begin
            lv = 2 * hi[SRC_GROUP[i]] + lo[SRC_GROUP[i]];
            if (rq[i] && lv > bl) begin
                bl = lv;
                b = i;
            end
        end
        return SRC_VECTOR[b];
    endfunction
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk) {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) sfr_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk) sfr_addr <= a;
        @(negedge sys_clk) `CK("sfr_rdata", e, sfr_rdata)
    endtask
    // Bounded wait for an offer, or for the core to be running again.
    task automatic wait_til(logic awake);
        for (n = 0; n < 30; n++) begin
            @(negedge sys_clk);
            if (awake ? cpu_halt === 1'b0 : irq_valid === 1'b1)
                return;
        end
        num_errors++;
        complete_run();
    endtask
    task automatic ret();
        @(posedge sys_clk) irq_ret <= 1'b1;
        @(posedge sys_clk) irq_ret <= 1'b0;
    endtask
    initial begin
        n = $urandom(32'hb020);
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(POWER_MODE_CONTROL_ADDR, POWER_MODE_RESET);
        rd(PRIO_HIGH_BITS_ADDR, 8'h00);
        rd(8'h55, 8'h00);
        // Random levels and requests; the core stalls, nothing is serviced.
        for (int t = 0; t < 40; t++) begin
            lo = (t < 2) ? {6{t[0]}} : 6'($urandom);
            hi = (t < 2) ? {6{t[0]}} : 6'($urandom);
            wr(PRIO_LOW_BITS_ADDR, {2'b00, lo});
            wr(PRIO_HIGH_BITS_ADDR, {2'b00, hi});
            rd(PRIO_LOW_BITS_ADDR, {2'b00, lo});
            @(posedge sys_clk) irq_req <= 10'($urandom) | 10'(1 << (t % 10));
            wait_til(1'b0);
            `CK("irq_vector", exp_vec(irq_req), irq_vector)
            @(posedge sys_clk) irq_req <= 10'h000;
        end
        // An equal level is refused while in service, offered after return.
        wr(PRIO_LOW_BITS_ADDR, 8'h00);
        wr(PRIO_HIGH_BITS_ADDR, 8'h21);
        @(posedge sys_clk) {ack_en, irq_req[SRC_T2]} <= 2'b11;
        wait_til(1'b0);
        repeat (4) @(negedge sys_clk);
        `CK("took_vec", 16'h002b, took_vec)
        @(posedge sys_clk) irq_req[SRC_EXT0] <= 1'b1;
        repeat (5) @(negedge sys_clk) ack_en <= 1'b0;
        `CK("irq_valid", 1'b0, irq_valid)
        ret();
        wait_til(1'b0);
        `CK("irq_vector", 16'h0003, irq_vector)
        @(posedge sys_clk) irq_req <= 10'h000;
        wr(POWER_MODE_CONTROL_ADDR, 8'h81);
        rd(POWER_MODE_CONTROL_ADDR, 8'h80);
        `CK("baud_doubler", 1'b1, baud_doubler)
        `CK("cpu_halt", 1'b1, cpu_halt)
        @(posedge sys_clk) irq_req[SRC_T1] <= 1'b1;
        wait_til(1'b1);
        // Stop ignores internal requests and wakes on each pin in turn.
        for (int p = 0; p < 3; p++) begin
            @(posedge sys_clk) irq_req <= 10'h000;
            wr(POWER_MODE_CONTROL_ADDR, 8'h42);
            @(posedge sys_clk) irq_req <= 10'($urandom) | 10'h004;
            repeat (10) @(negedge sys_clk);
            `CK("clk_gate_off", 1'b1, clk_gate_off)
            @(posedge sys_clk) pins <= 3'(1 << p);
            wait_til(1'b1);
            @(posedge sys_clk) pins <= 3'h0;
        end
        // Both mode bits at once: stop wins; then a reset ends stop.
        wr(POWER_MODE_CONTROL_ADDR, 8'h83);
        @(negedge sys_clk) `CK("clk_gate_off", 1'b1, clk_gate_off)
        @(posedge sys_clk) resetn <= 1'b0;
        repeat (2) @(posedge sys_clk) resetn <= 1'b1;
        @(negedge sys_clk) `CK("cpu_halt", 1'b0, cpu_halt)
        `CK("baud_doubler", 1'b0, baud_doubler)
        rd(PRIO_HIGH_BITS_ADDR, 8'h00);
        complete_run();
    end
endmodule // tb_ipm_ctrl
